// *** core/gpb_io_ports.sv ***
`default_nettype none
module gpb_io_ports
  import gpb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NP-1:0][PW-1:0] padIn,
  output logic [NP-1:0][PW-1:0] padOut,
  output logic [NP-1:0][PW-1:0] padOeN,
  output logic [NP-1:0][PW-1:0] padPullUp,
  input wire logic oscClockIn,
  input wire logic watchdogFaultIn,
  input wire logic [PW-1:0] gAltOut,
  input wire logic [PW-1:0] gAltEn,
  output logic haltReq,
  output logic idleReq,
  output logic shiftClockPhaseSel,
  output logic haltRestartDelayEn,
  output logic extIrqIn,
  output logic timer1CapturePin,
  output logic timer1IoPin,
  output logic serialShiftClock,
  output logic serialDataIn,
  output logic wakeEvent
);
  gpb_state_t q;
  gpb_state_t d;
  logic [2:0] idx;
  logic [1:0] sel;
  logic hitPort;
  logic hitOpt;
  logic setupPh;
  logic wrAcc;

  // Address decode and phase qualifiers
  assign idx = paddr[6:4];
  assign sel = paddr[3:2];
  assign hitPort = (idx < 3'(NP)) && (sel <= REG_PIN) && (paddr[1:0] == 2'h0) && !paddr[7];
  assign hitOpt = (paddr == ADDR_OPTION);
  assign setupPh = psel && !penable;
  assign wrAcc = psel && penable && q.ready && pwrite && pstrb[0];

  // Next state of the whole block
  always_comb
  begin
    d = q;
    d.ready = setupPh;
    d.err = 1'b0;
    d.halt = 1'b0;
    d.idle = 1'b0;
    // Three-stage pin sampling, level follows when stages two and three agree
    d.sync1 = padIn;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int p = 0; p < NP; p++)
    begin
      for (int b = 0; b < PW; b++)
      begin
        if (q.sync2[p][b] == q.sync3[p][b])
        begin
          d.level[p][b] = q.sync2[p][b];
        end
      end
    end
    // Wake on any filtered change of port L
    d.wake = |(d.level[PORT_L] ^ q.level[PORT_L]); // R14
    // Read data prepared in the setup phase, shown in the access phase
    if (setupPh)
    begin
      d.rdata = 32'h0000_0000;
      d.err = !(hitPort || hitOpt);
      if (!pwrite && hitOpt)
      begin
        d.rdata[OPT_WDOG_BIT] = q.wdogSel;
      end
      else if (!pwrite && hitPort)
      begin
        case (sel)
          REG_SETUP: d.rdata[PW-1:0] = q.setup[idx]; // R1
          REG_OUTPUT:
          begin
            d.rdata[PW-1:0] = q.outData[idx];
            if (idx == PORT_G)
            begin
              d.rdata[PW-1:0] = q.outData[idx] & ~G_SPECIAL_MASK; // R8
            end
          end
          REG_PIN: d.rdata[PW-1:0] = q.level[idx]; // R15 R4
          default: d.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Register writes at the access edge
    if (wrAcc && hitOpt)
    begin
      d.wdogSel = pwdata[OPT_WDOG_BIT];
    end
    if (wrAcc && hitPort)
    begin
      case (sel)
        REG_SETUP: d.setup[idx] = pwdata[PW-1:0]; // R1 R3 R11 R12
        REG_OUTPUT:
        begin
          d.outData[idx] = pwdata[PW-1:0]; // R1 R3
          if (idx == PORT_G)
          begin
            d.outData[idx] = pwdata[PW-1:0] & ~G_SPECIAL_MASK; // R8
            d.halt = pwdata[G_HALT]; // R9
            d.idle = pwdata[G_IDLE]; // R10
          end
        end
        default: d.wdogSel = d.wdogSel;
      endcase
    end
    // Pad drive from setup and output bits
    for (int p = 0; p < NP; p++)
    begin
      for (int b = 0; b < PW; b++)
      begin
        d.padOeN[p][b] = !d.setup[p][b]; // R2 R3 R7
        d.padOut[p][b] = d.outData[p][b]; // R2
        d.padPullUp[p][b] = !d.setup[p][b] && d.outData[p][b]; // R2
      end
    end
    // Peripheral outputs on port G
    for (int b = 0; b < PW; b++)
    begin
      if (G_ALT_OUT_MASK[b] && gAltEn[b])
      begin
        d.padOeN[PORT_G][b] = 1'b0; // R13
        d.padOut[PORT_G][b] = gAltOut[b]; // R13
        d.padPullUp[PORT_G][b] = 1'b0;
      end
    end
    // Watchdog pin: pull-up, pulled low on a fault
    if (d.wdogSel)
    begin
      d.padOeN[PORT_G][G_WDOG] = !watchdogFaultIn; // R6
      d.padOut[PORT_G][G_WDOG] = 1'b0; // R6
      d.padPullUp[PORT_G][G_WDOG] = 1'b1; // R6
    end
    // Dedicated input and clock output pins
    d.padOeN[PORT_G][G_SIN] = 1'b1; // R5
    d.padOut[PORT_G][G_SIN] = 1'b0; // R5
    d.padPullUp[PORT_G][G_SIN] = 1'b0; // R5
    d.padOeN[PORT_G][G_CKO] = 1'b0; // R5
    d.padOut[PORT_G][G_CKO] = oscClockIn; // R5
    d.padPullUp[PORT_G][G_CKO] = 1'b0; // R5
  end

  // State register, all zero at reset except padOeN, which resets to all ones
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      q <= '0; // R16
      q.padOeN <= '1; // R16
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign padOut = q.padOut;
  assign padOeN = q.padOeN;
  assign padPullUp = q.padPullUp;
  assign haltReq = q.halt;
  assign idleReq = q.idle;
  assign shiftClockPhaseSel = q.setup[PORT_G][G_PHASE]; // R11
  assign haltRestartDelayEn = q.setup[PORT_G][G_DELAY]; // R12
  assign extIrqIn = q.level[PORT_G][G_EXT_IRQ_IN]; // R13
  assign timer1CapturePin = q.level[PORT_G][G_T1CAP]; // R13
  assign timer1IoPin = q.level[PORT_G][G_T1IO]; // R13
  assign serialShiftClock = q.level[PORT_G][G_SCLK]; // R13
  assign serialDataIn = q.level[PORT_G][G_SIN]; // R13
  assign wakeEvent = q.wake;
endmodule
`default_nettype wire

// *** core/gpb_pkg.sv ***
// Operation
// (R1) Each port has setup, output and pin-input byte registers on the bus.
// (R2) Setup and output bit pair picks hi-Z, pull-up, drive zero or drive one.
// (R3) Every bit of every port is set up on its own by software; the code fixes G6 and G7 and uses their setup bits for R11 and R12.
// (R4) Unbonded port A bits read an undetermined level, nothing is guaranteed.
// (R5) G6 is always a hi-Z input; G7 always drives the oscillator clock.
// (R6) With watchdog selected, G1 is the watchdog output with weak pull-up.
// (R7) Without watchdog selected, G1 is an ordinary I/O bit.
// (R8) Port G output register reads zero in bits 6 and 7.
// (R9) Writing one to port G output bit 7 requests halt mode.
// (R10) Writing one to port G output bit 6 requests idle mode.
// (R11) Port G setup bit 6 selects the alternate serial shift clock phase.
// (R12) Port G setup bit 7 enables the clock start-up delay after halt.
// (R13) Port G pins carry serial, timer 1 and external interrupt functions.
// (R14) Any change on the eight port L pins raises a wake-up event.
// (R15) Pin input register returns the sampled pin level whatever the setup.
// (R16) Reset clears setup and output bits so all pins start as hi-Z inputs.
`default_nettype none
package gpb_pkg;
  localparam int NP = 5;
  localparam int PW = 8;
  // Port indices
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_G = 3'h2;
  localparam logic [2:0] PORT_H = 3'h3;
  localparam logic [2:0] PORT_L = 3'h4;
  // Byte address = port index * 0x10 + register offset * 4
  localparam logic [1:0] REG_SETUP = 2'h0;
  localparam logic [1:0] REG_OUTPUT = 2'h1;
  localparam logic [1:0] REG_PIN = 2'h2;
  localparam logic [7:0] ADDR_OPTION = 8'h50;
  localparam int OPT_WDOG_BIT = 0;
  // Port G bit positions
  localparam int G_EXT_IRQ_IN = 0;
  localparam int G_WDOG = 1;
  localparam int G_T1CAP = 2;
  localparam int G_T1IO = 3;
  localparam int G_SOUT = 4;
  localparam int G_SCLK = 5;
  localparam int G_SIN = 6;
  localparam int G_CKO = 7;
  localparam int G_IDLE = 6;
  localparam int G_HALT = 7;
  localparam int G_PHASE = 6;
  localparam int G_DELAY = 7;
  // Bits of port G that peripherals may drive
  localparam logic [7:0] G_ALT_OUT_MASK = 8'h38;
  localparam logic [7:0] G_SPECIAL_MASK = 8'hc0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef logic [NP-1:0][PW-1:0] gpb_bytes_t;
  typedef struct packed {
    gpb_bytes_t setup;
    gpb_bytes_t outData;
    gpb_bytes_t sync1;
    gpb_bytes_t sync2;
    gpb_bytes_t sync3;
    gpb_bytes_t level;
    gpb_bytes_t padOut;
    gpb_bytes_t padOeN;
    gpb_bytes_t padPullUp;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic halt;
    logic idle;
    logic wake;
    logic wdogSel;
  } gpb_state_t;
endpackage
`default_nettype wire

// *** tb/gpb_board.sv ***
`default_nettype none
module gpb_board
  import gpb_pkg::*;
(
  input wire logic clock,
  input wire gpb_bytes_t padOut,
  input wire gpb_bytes_t padOeN,
  input wire gpb_bytes_t padPullUp,
  input wire gpb_bytes_t ext,
  input wire gpb_bytes_t extEn,
  output var gpb_bytes_t padIn
);
  timeunit 1ns;
  timeprecision 1ns;
  gpb_bytes_t flt = '0;
  // Undriven pins wander
  always @(posedge clock)
    flt <= ~flt;
  // Device drive wins, then board drive, then pull-up
  assign padIn = ~padOeN & padOut | padOeN & (extEn & ext | ~extEn & (padPullUp | flt));
endmodule
`default_nettype wire

// *** tb/gpb_io_ports_assertions.sv ***
`default_nettype none
module gpb_chk
  import gpb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NP-1:0][PW-1:0] padOut,
  input wire logic [NP-1:0][PW-1:0] padOeN,
  input wire logic [NP-1:0][PW-1:0] padPullUp,
  input wire logic oscClockIn,
  input wire logic haltReq,
  input wire logic idleReq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_gwrite;
    psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h24;
  endsequence
  a_ready_zero_wait: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_unmapped_error: assert property (s_setup ##0 paddr == 8'h60 |=> pslverr && !prdata)
    else $error("unmapped access not refused");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_halt_pulse: assert property (s_gwrite |=> haltReq == $past(pwdata[7]))
    else $error("halt request wrong");
  a_idle_pulse: assert property (s_gwrite |=> idleReq == $past(pwdata[6]))
    else $error("idle request wrong");
  a_g6_input: assert property (padOeN[2][6] && !padPullUp[2][6])
    else $error("input-only pin driven");
  a_g7_clock: assert property (!$past(rst) |-> !padOeN[2][7] && padOut[2][7] == $past(oscClockIn))
    else $error("clock pin wrong");
  a_pull_not_drive: assert property (&(padOeN[1] | ~padPullUp[1]))
    else $error("pull-up while driving");
  a_reset_hiz: assert property ($fell(rst) |=> padOeN[1] == 8'hff && padPullUp[1] == 8'h00)
    else $error("pins not hi-Z after reset");
endmodule
bind gpb_io_ports gpb_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .padOut(padOut), .padOeN(padOeN),
  .padPullUp(padPullUp), .oscClockIn(oscClockIn), .haltReq(haltReq), .idleReq(idleReq));
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
  import gpb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, osc = 0, wdog = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, haltReq, idleReq, phs, dly, irq, tcap, tio, sck, sdi, wake;
  gpb_bytes_t padIn, padOut, padOeN, padPullUp, ext = '0, extEn = '0;
  int bad_count = 0, compares = 0;
  // Clock and oscillator
  always #10 clock = ~clock;
  always @(posedge clock) osc <= ~osc;
  gpb_io_ports dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp),
    .oscClockIn(osc), .watchdogFaultIn(wdog), .gAltOut(8'h00), .gAltEn(8'h00),
    .haltReq(haltReq), .idleReq(idleReq), .shiftClockPhaseSel(phs), .haltRestartDelayEn(dly),
    .extIrqIn(irq), .timer1CapturePin(tcap), .timer1IoPin(tio), .serialShiftClock(sck),
    .serialDataIn(sdi), .wakeEvent(wake));
  gpb_board pins (.clock(clock), .padOut(padOut), .padOeN(padOeN), .padPullUp(padPullUp),
    .ext(ext), .extEn(extEn), .padIn(padIn));
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
    begin
      bad_count++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic t_reset();
    for (int p = 0; p < 5; p++)
    begin
      apb(8'(p * 16), 0, 8'h00);
      chk("setup reset", 32'h0, rd);
      apb(8'(p * 16 + 4), 0, 8'h00);
      chk("output reset", 32'h0, rd);
    end
    chk("oen reset", 8'hff, padOeN[1]);
    apb(8'h60, 0, 8'h00);
    chk("unmapped", 1, er);
  endtask
  task automatic t_modes();
    apb(8'h10, 1, 8'h0f);
    apb(8'h14, 1, 8'h55);
    chk("b oen", 8'hf0, padOeN[1]);
    chk("b pull", 8'h50, padPullUp[1]);
    repeat (5) @(posedge clock);
    apb(8'h18, 0, 8'h00);
    chk("b pin", 32'h55, rd & 32'h5f);
  endtask
  task automatic t_portg();
    apb(8'h24, 1, 8'hff);
    apb(8'h24, 0, 8'h00);
    chk("g out read", 32'h3f, rd);
    apb(8'h20, 1, 8'hc0);
    chk("phase delay", 2'h3, {phs, dly});
    apb(8'h24, 1, 8'h00);
  endtask
  task automatic t_wdog();
    apb(8'h50, 1, 8'h01);
    apb(8'h20, 1, 8'h02);
    chk("wdog idle", 2'h3, {padOeN[2][1], padPullUp[2][1]});
    wdog <= 1;
    repeat (2) @(posedge clock);
    chk("wdog fault", 2'h0, {padOeN[2][1], padOut[2][1]});
    wdog <= 0;
    apb(8'h50, 1, 8'h00);
    apb(8'h24, 1, 8'h02);
    chk("g1 gpio", 2'h1, {padOeN[2][1], padOut[2][1]});
  endtask
  task automatic t_alt();
    int n;
    n = 0;
    ext[2] <= 8'h4d;
    extEn[2] <= 8'h6d;
    repeat (5) @(posedge clock);
    chk("g alt", 5'h17, {sdi, sck, tio, tcap, irq});
    ext[4] <= 8'h80;
    while (wake !== 1'b1 && n < 10)
    begin
      @(posedge clock);
      n++;
    end
    chk("wake", 1, wake);
  endtask
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    extEn[4] = 8'hff;
    repeat (6) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    t_reset();
    t_modes();
    t_portg();
    t_wdog();
    t_alt();
    report_and_stop();
  end
  // Hang guard
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
